//--- core/acr_defines.vh
/*
  constants for the analog configuration register block: command codes,
  frame fields, register indexes, protocol codes and default values.
  assumes it is included by bare name from the core/ design files.
*/
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ----------------------------------------------------------------------
// command codes and frame fields
// ----------------------------------------------------------------------
`define ACR_CMD_PROTO      8'h02
`define ACR_CMD_READ       8'h08
`define ACR_CMD_WRITE      8'h09
`define ACR_ADDR_INDEX     8'h68
`define ACR_ADDR_READ      8'h69
`define ACR_ADDR_SUPPLY    8'h6A
`define ACR_FLAG_KEEP      8'h00
`define ACR_FLAG_INC       8'h01
`define ACR_LEN_SHORT      8'h03
`define ACR_LEN_LONG       8'h04
`define ACR_READ_SIZE      8'h01
`define ACR_READ_RSVD      8'h00
`define ACR_RES_OK         8'h00
`define ACR_RES_ERR_LEN    8'h82
`define ACR_RSP_LEN_NONE   8'h00
`define ACR_RSP_LEN_ONE    8'h01
`define ACR_HDR_BYTES      4'h2
`define ACR_MAX_BYTES      4'h6
`define ACR_CNT_ONE        4'h1
`define ACR_ZERO_BYTE      8'h00
`define ACR_SUPPLY_BIT     0

// ----------------------------------------------------------------------
// register indexes and fields
// ----------------------------------------------------------------------
`define ACR_IDX_READER     8'h01
`define ACR_IDX_CARD       8'h04
`define ACR_IDX_ONE        8'h01
`define ACR_RESET_VALUE    8'h00
`define ACR_MOD_MSB        7
`define ACR_MOD_LSB        4
`define ACR_GAIN_MSB       3
`define ACR_GAIN_LSB       0
`define ACR_SENS_MSB       5
`define ACR_SENS_LSB       4
`define ACR_LOAD_MSB       3
`define ACR_LOAD_LSB       0

// ----------------------------------------------------------------------
// protocol codes and defaults
// ----------------------------------------------------------------------
`define ACR_PROT_VICINITY  8'h01
`define ACR_PROT_TYPE_A    8'h02
`define ACR_PROT_TYPE_B    8'h03
`define ACR_PROT_JP        8'h04
`define ACR_PROT_CARD_A    8'h12
`define ACR_PARAM_MOD100   4
`define ACR_DEF_TYPE_A     8'hDF
`define ACR_DEF_TYPE_B     8'h20
`define ACR_DEF_JP         8'h50
`define ACR_DEF_VIC10      8'h53
`define ACR_DEF_VIC100     8'hD3
`define ACR_DEF_CARD       8'h27

// ----------------------------------------------------------------------
// decoded figures: modulation percent and receiver gain in dB
// ----------------------------------------------------------------------
`define ACR_MOD_C1         4'h1
`define ACR_MOD_C2         4'h2
`define ACR_MOD_C3         4'h3
`define ACR_MOD_C4         4'h4
`define ACR_MOD_C5         4'h5
`define ACR_MOD_C6         4'h6
`define ACR_MOD_CD         4'hD
`define ACR_PCT_C1         7'h0A
`define ACR_PCT_C2         7'h11
`define ACR_PCT_C3         7'h19
`define ACR_PCT_C4         7'h1E
`define ACR_PCT_C5         7'h21
`define ACR_PCT_C6         7'h24
`define ACR_PCT_CD         7'h5F
`define ACR_PCT_NONE       7'h00
`define ACR_GAIN_C0        4'h0
`define ACR_GAIN_C1        4'h1
`define ACR_GAIN_C3        4'h3
`define ACR_GAIN_C7        4'h7
`define ACR_GAIN_CF        4'hF
`define ACR_DB_C0          6'h22
`define ACR_DB_C1          6'h20
`define ACR_DB_C3          6'h1B
`define ACR_DB_C7          6'h14
`define ACR_DB_CF          6'h08
`define ACR_DB_NONE        6'h00

`endif

//--- core/acr_proto_defaults.v
/*
  lookup of the default analog configuration values for a protocol code.
  assumes the caller loads both values only when o_known is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "acr_defines.vh"

module acr_proto_defaults (
  input  wire [7:0] i_protocol,
  input  wire [7:0] i_param,
  output reg        o_known,
  output reg  [7:0] o_reader_default,
  output wire [7:0] o_card_default
);

  // card register has one documented default; every known protocol loads it
  assign o_card_default = `ACR_DEF_CARD;

  // ----------------------------------------------------------------------
  // per protocol reader defaults
  // ----------------------------------------------------------------------
  always @* begin
    o_known          = 1'b1;
    o_reader_default = `ACR_DEF_TYPE_A;
    case (i_protocol)
      `ACR_PROT_TYPE_A:   o_reader_default = `ACR_DEF_TYPE_A;
      `ACR_PROT_TYPE_B:   o_reader_default = `ACR_DEF_TYPE_B;
      `ACR_PROT_JP:       o_reader_default = `ACR_DEF_JP;
      `ACR_PROT_VICINITY: o_reader_default = i_param[`ACR_PARAM_MOD100] ?
                                             `ACR_DEF_VIC100 : `ACR_DEF_VIC10;
      `ACR_PROT_CARD_A:   o_reader_default = `ACR_DEF_TYPE_A;
      default:            o_known = 1'b0;
    endcase
  end

endmodule // acr_proto_defaults
`default_nettype wire

//--- core/acr_regs.v
/*
  analog configuration register bank behind a byte-wide command stream:
  protocol select, register write and register read frames, answered on
  a byte-wide response stream.
  assumes the serial link framer runs on i_core_clk and marks the last
  byte of each frame; bytes of a frame may arrive with gaps.
*/
`timescale 1ns/100ps
`default_nettype none
`include "acr_defines.vh"

module acr_regs (
  input  wire       i_core_clk,
  input  wire       i_reset_n,
  input  wire       i_clk_en,
  input  wire       i_cmd_valid,
  input  wire [7:0] i_cmd_byte,
  input  wire       i_cmd_last,
  output reg        o_cmd_ready,
  output reg        o_rsp_valid,
  output reg  [7:0] o_rsp_byte,
  output reg        o_rsp_last,
  input  wire       i_rsp_ready,
  output reg  [3:0] o_mod_index,
  output reg  [3:0] o_rx_gain,
  output reg  [6:0] o_mod_percent,
  output reg  [5:0] o_rx_gain_db,
  output reg  [3:0] o_load_mod_index,
  output reg  [1:0] o_demod_sens,
  output reg        o_driver_supply_saving,
  output reg        o_reader_mode_possible
);

  localparam [1:0] ST_RECV = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_RESP = 2'b10;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [1:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] frame_q [0:5];
  reg  [7:0] reader_q;
  reg  [7:0] card_q;
  reg  [7:0] index_q;
  reg  [7:0] rsp_q [0:2];
  reg  [1:0] rsp_cnt_q;
  reg  [1:0] rsp_pos_q;
  wire       known;
  wire [7:0] reader_def;
  wire [7:0] card_def;
  wire       take;
  wire [7:0] sel_data;
  wire [3:0] len_ok_long;
  wire [3:0] len_ok_short;
  wire [7:0] len_sum_long;
  wire [7:0] len_sum_short;
  reg        write_len_ok;
  reg        read_frame_ok;
  reg        index_write;
  reg        supply_write;
  integer    k;

  assign take          = i_clk_en && o_cmd_ready && i_cmd_valid;
  // sums taken at byte width, then cut to the counter width on purpose
  assign len_sum_long  = {4'h0, `ACR_HDR_BYTES} + `ACR_LEN_LONG;
  assign len_sum_short = {4'h0, `ACR_HDR_BYTES} + `ACR_LEN_SHORT;
  assign len_ok_long   = len_sum_long[3:0];
  assign len_ok_short  = len_sum_short[3:0];

  assign sel_data = (index_q == `ACR_IDX_READER) ? reader_q :
                    (index_q == `ACR_IDX_CARD)   ? card_q   : `ACR_ZERO_BYTE;

  acr_proto_defaults u_defaults (
    .i_protocol       (frame_q[2]),
    .i_param          (frame_q[3]),
    .o_known          (known),
    .o_reader_default (reader_def),
    .o_card_default   (card_def)
  );

  // ----------------------------------------------------------------------
  // frame checks ahead of the execute step
  // ----------------------------------------------------------------------
  // for write and read frames the length byte and byte count must agree, so a cut or padded one is refused
  always @* begin
    write_len_ok  = 1'b0;
    read_frame_ok = 1'b0;
    index_write   = 1'b0;
    supply_write  = 1'b0;
    if (frame_q[1] == `ACR_LEN_SHORT && cnt_q == len_ok_short) begin
      write_len_ok = 1'b1;
    end else if (frame_q[1] == `ACR_LEN_LONG && cnt_q == len_ok_long) begin
      write_len_ok = 1'b1;
    end
    if (frame_q[1] == `ACR_LEN_SHORT && cnt_q == len_ok_short &&
        frame_q[2] == `ACR_ADDR_READ && frame_q[3] == `ACR_READ_SIZE &&
        frame_q[4] == `ACR_READ_RSVD) begin
      read_frame_ok = 1'b1;
    end
    if (frame_q[2] == `ACR_ADDR_INDEX) begin
      index_write = 1'b1;
    end
    // supply saving address, long frames only
    if (frame_q[2] == `ACR_ADDR_SUPPLY && frame_q[1] == `ACR_LEN_LONG) begin
      supply_write = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // frame capture, execution and response
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q                <= ST_RECV;
      cnt_q                  <= 4'h0;
      reader_q               <= `ACR_RESET_VALUE;
      card_q                 <= `ACR_RESET_VALUE;
      index_q                <= `ACR_RESET_VALUE;
      o_driver_supply_saving <= 1'b0;
      rsp_cnt_q              <= 2'd0;
      rsp_pos_q              <= 2'd0;
      o_cmd_ready            <= 1'b0;
      o_rsp_valid            <= 1'b0;
      o_rsp_byte             <= `ACR_ZERO_BYTE;
      o_rsp_last             <= 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        frame_q[k] <= `ACR_ZERO_BYTE;
      end
      for (k = 0; k < 3; k = k + 1) begin
        rsp_q[k] <= `ACR_ZERO_BYTE;
      end
    end else if (i_clk_en) begin
      case (state_q)
        ST_RECV: begin
          o_cmd_ready <= 1'b1;
          if (take) begin
            // bytes past the sixth are counted but not kept
            if (cnt_q < `ACR_MAX_BYTES) begin
              frame_q[cnt_q[2:0]] <= i_cmd_byte;
            end
            if (cnt_q != 4'hF) begin
              cnt_q <= cnt_q + `ACR_CNT_ONE;
            end
            if (i_cmd_last) begin
              o_cmd_ready <= 1'b0;
              state_q     <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          state_q   <= ST_RESP;
          rsp_pos_q <= 2'd0;
          rsp_q[0]  <= `ACR_RES_OK;
          rsp_q[1]  <= `ACR_RSP_LEN_NONE;
          rsp_cnt_q <= 2'd2;
          case (frame_q[0])
            `ACR_CMD_PROTO: begin
              if (known) begin
                reader_q <= reader_def;
                card_q   <= card_def;
              end
            end
            `ACR_CMD_WRITE: begin
              if (write_len_ok) begin
                if (index_write) begin
                  if (frame_q[1] == `ACR_LEN_SHORT) begin
                    index_q <= frame_q[4];
                  end else begin
                    // write replaces only the addressed register
                    if (frame_q[4] == `ACR_IDX_READER) begin
                      reader_q <= frame_q[5];
                    end else if (frame_q[4] == `ACR_IDX_CARD) begin
                      card_q <= frame_q[5];
                    end
                    if (frame_q[3] == `ACR_FLAG_INC) begin
                      index_q <= frame_q[4] + `ACR_IDX_ONE;
                    end else begin
                      index_q <= frame_q[4];
                    end
                  end
                end else if (supply_write) begin
                  o_driver_supply_saving <= frame_q[5][`ACR_SUPPLY_BIT];
                end
              end else begin
                rsp_q[0] <= `ACR_RES_ERR_LEN;
              end
            end
            `ACR_CMD_READ: begin
              if (read_frame_ok) begin
                rsp_q[1]  <= `ACR_RSP_LEN_ONE;
                rsp_q[2]  <= sel_data;
                rsp_cnt_q <= 2'd3;
              end else begin
                rsp_q[0] <= `ACR_RES_ERR_LEN;
              end
            end
            default: begin
              // unknown commands are dropped without an answer
              rsp_cnt_q <= 2'd0;
              state_q   <= ST_RECV;
              cnt_q     <= 4'h0;
              o_cmd_ready <= 1'b1;
            end
          endcase
        end
        ST_RESP: begin
          if (!o_rsp_valid || i_rsp_ready) begin
            if (o_rsp_valid && o_rsp_last) begin
              o_rsp_valid <= 1'b0;
              o_rsp_last  <= 1'b0;
              cnt_q       <= 4'h0;
              state_q     <= ST_RECV;
            end else begin
              o_rsp_valid <= 1'b1;
              o_rsp_byte  <= rsp_q[rsp_pos_q];
              o_rsp_last  <= (rsp_pos_q + 2'd1 == rsp_cnt_q);
              rsp_pos_q   <= rsp_pos_q + 2'd1;
            end
          end
        end
        default: begin
          state_q <= ST_RECV;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // field decode; registered so every output comes from a flop
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mod_index            <= 4'h0;
      o_rx_gain              <= 4'h0;
      o_mod_percent          <= `ACR_PCT_NONE;
      o_rx_gain_db           <= `ACR_DB_NONE;
      o_load_mod_index       <= 4'h0;
      o_demod_sens           <= 2'h0;
      o_reader_mode_possible <= 1'b1;
    end else if (i_clk_en) begin
      o_mod_index      <= reader_q[`ACR_MOD_MSB:`ACR_MOD_LSB];
      o_rx_gain        <= reader_q[`ACR_GAIN_MSB:`ACR_GAIN_LSB];
      o_load_mod_index <= card_q[`ACR_LOAD_MSB:`ACR_LOAD_LSB];
      o_demod_sens     <= card_q[`ACR_SENS_MSB:`ACR_SENS_LSB];
      o_reader_mode_possible <= !o_driver_supply_saving;
      case (reader_q[`ACR_MOD_MSB:`ACR_MOD_LSB])
        `ACR_MOD_C1: o_mod_percent <= `ACR_PCT_C1;
        `ACR_MOD_C2: o_mod_percent <= `ACR_PCT_C2;
        `ACR_MOD_C3: o_mod_percent <= `ACR_PCT_C3;
        `ACR_MOD_C4: o_mod_percent <= `ACR_PCT_C4;
        `ACR_MOD_C5: o_mod_percent <= `ACR_PCT_C5;
        `ACR_MOD_C6: o_mod_percent <= `ACR_PCT_C6;
        `ACR_MOD_CD: o_mod_percent <= `ACR_PCT_CD;
        default:     o_mod_percent <= `ACR_PCT_NONE;
      endcase
      case (reader_q[`ACR_GAIN_MSB:`ACR_GAIN_LSB])
        `ACR_GAIN_C0: o_rx_gain_db <= `ACR_DB_C0;
        `ACR_GAIN_C1: o_rx_gain_db <= `ACR_DB_C1;
        `ACR_GAIN_C3: o_rx_gain_db <= `ACR_DB_C3;
        `ACR_GAIN_C7: o_rx_gain_db <= `ACR_DB_C7;
        `ACR_GAIN_CF: o_rx_gain_db <= `ACR_DB_CF;
        default:      o_rx_gain_db <= `ACR_DB_NONE;
      endcase
    end
  end

endmodule // acr_regs
`default_nettype wire

//--- verification/acr_regs_assertions.sv
/*
  port checker for acr_regs: response framing, timing and field outputs.
  assumes a single clock domain and one frame in flight at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module acr_regs_assertions (
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       i_clk_en,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic       i_cmd_last,
  input wire logic       o_cmd_ready,
  input wire logic       o_rsp_valid,
  input wire logic [7:0] o_rsp_byte,
  input wire logic       o_rsp_last,
  input wire logic       i_rsp_ready,
  input wire logic [3:0] o_mod_index,
  input wire logic [3:0] o_rx_gain,
  input wire logic [6:0] o_mod_percent,
  input wire logic [5:0] o_rx_gain_db,
  input wire logic [3:0] o_load_mod_index,
  input wire logic [1:0] o_demod_sens,
  input wire logic       o_driver_supply_saving,
  input wire logic       o_reader_mode_possible
);
  logic       take;
  logic       known;
  logic       sof_q;
  logic [7:0] cmd_q;
  logic [1:0] rcnt_q;
  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  // unknown command codes get no answer, so the timing check needs the code
  assign take  = i_cmd_valid && o_cmd_ready && i_clk_en;
  assign known = (sof_q ? i_cmd_byte : cmd_q) inside {8'h02, 8'h08, 8'h09};
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sof_q  <= 1'b1;
      cmd_q  <= 8'h00;
      rcnt_q <= 2'h0;
    end else begin
      if (take) sof_q <= i_cmd_last;
      if (take && sof_q) cmd_q <= i_cmd_byte;
      if (o_rsp_valid && i_rsp_ready && i_clk_en) rcnt_q <= o_rsp_last ? 2'h0 : rcnt_q + 2'h1;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_mode_follows_saving: assert property (i_clk_en |=>
    o_reader_mode_possible == !$past(o_driver_supply_saving)) else $error("mode flag lag");
  a_rsp_holds: assert property (o_rsp_valid && !(i_rsp_ready && i_clk_en) |=>
    o_rsp_valid && $stable(o_rsp_byte) && $stable(o_rsp_last)) else $error("response moved");
  a_ready_off_rsp: assert property (o_rsp_valid |-> !o_cmd_ready)
    else $error("ready during response");
  a_answer_time: assert property (take && i_cmd_last && known ##1 i_clk_en [*3]
    |-> o_rsp_valid) else $error("late answer");
  a_error_length: assert property (o_rsp_valid && rcnt_q == 2'h0 && o_rsp_byte == 8'h82
    && i_rsp_ready && i_clk_en |=> o_rsp_valid && o_rsp_byte == 8'h00 && o_rsp_last)
    else $error("bad error reply");
  a_first_result: assert property (o_rsp_valid && rcnt_q == 2'h0 |->
    o_rsp_byte inside {8'h00, 8'h82} && !o_rsp_last) else $error("bad result byte");
  a_len_byte: assert property (o_rsp_valid && rcnt_q == 2'h1 |->
    o_rsp_last == (o_rsp_byte == 8'h00)) else $error("length and last disagree");
  a_data_last: assert property (o_rsp_valid && rcnt_q == 2'h2 |-> o_rsp_last)
    else $error("data byte not last");
  a_mod_d_pct: assert property (o_mod_index == 4'hD && $past(o_mod_index) == 4'hD
    |-> o_mod_percent == 7'h5F) else $error("bad percent");
  a_gain_f_db: assert property (o_rx_gain == 4'hF && $past(o_rx_gain) == 4'hF
    |-> o_rx_gain_db == 6'h08) else $error("bad gain");
  a_fields_quiet: assert property ($changed(o_mod_index) || $changed(o_rx_gain)
    || $changed(o_load_mod_index) || $changed(o_demod_sens) |-> !o_cmd_ready)
    else $error("field changed while idle");
  c_read_data: cover property (o_rsp_valid && rcnt_q == 2'h2);
  c_error: cover property (o_rsp_valid && o_rsp_byte == 8'h82);
  c_saving: cover property (o_driver_supply_saving);
endmodule // acr_regs_assertions
bind acr_regs acr_regs_assertions chk_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_clk_en(i_clk_en), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
  .i_cmd_last(i_cmd_last), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
  .o_rsp_byte(o_rsp_byte), .o_rsp_last(o_rsp_last), .i_rsp_ready(i_rsp_ready),
  .o_mod_index(o_mod_index), .o_rx_gain(o_rx_gain), .o_mod_percent(o_mod_percent),
  .o_rx_gain_db(o_rx_gain_db), .o_load_mod_index(o_load_mod_index),
  .o_demod_sens(o_demod_sens), .o_driver_supply_saving(o_driver_supply_saving),
  .o_reader_mode_possible(o_reader_mode_possible));
`default_nettype wire

//--- verification/acr_host_model.sv
/*
  host controller model: sends command frames byte by byte and collects
  the answer, promptly or with a stalled response ready.
  assumes the caller enters its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module acr_host_model (
  input wire logic       i_clk,
  input wire logic       i_cmd_ready,
  input wire logic       i_rsp_valid,
  input wire logic [7:0] i_rsp_byte,
  input wire logic       i_rsp_last,
  output var logic       o_cmd_valid,
  output var logic [7:0] o_cmd_byte,
  output var logic       o_cmd_last,
  output var logic       o_rsp_ready
);
  bit slow = 1'b0;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte  = 8'h00;
    o_cmd_last  = 1'b0;
    o_rsp_ready = 1'b1;
  end
  task automatic set_slow(input bit s);
    slow        = s;
    o_rsp_ready = !s;
  endtask
  task automatic send_frame(input logic [55:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      o_cmd_valid = 1'b1;
      o_cmd_byte  = f[8*(n-1-i) +: 8];
      o_cmd_last  = (i == n - 1);
      do @(negedge i_clk); while (i_cmd_ready !== 1'b1);
      @(posedge i_clk);
      #1;
    end
    o_cmd_valid = 1'b0;
    o_cmd_last  = 1'b0;
    // idle byte lines show no stale value
    o_cmd_byte  = ~o_cmd_byte;
  endtask
  task automatic get_resp(output logic [23:0] r, output int k);
    bit done;
    r = 24'h000000;
    k = 0;
    do begin
      do @(negedge i_clk); while (i_rsp_valid !== 1'b1);
      if (slow) begin
        repeat (2) @(posedge i_clk);
        #1;
        o_rsp_ready = 1'b1;
        @(negedge i_clk);
      end
      r    = {r[15:0], i_rsp_byte};
      k++;
      done = i_rsp_last;
      @(posedge i_clk);
      #1;
      if (slow) o_rsp_ready = 1'b0;
    end while (!done);
  endtask
endmodule // acr_host_model
`default_nettype wire

//--- verification/acr_regs_tb_top.sv
/*
  self-checking bench for acr_regs: frames sent through the host model,
  answers and field outputs compared with values from the rules.
  assumes i_clk_en held high; the checker is bound separately.
*/
`timescale 1ns/100ps
`default_nettype none
`include "acr_defines.vh"
module acr_regs_tb_top;
  localparam logic [191:0] PSEL = 192'h020201000202011002020200020203000202040002021208;
  localparam logic [47:0]  PDEF = 48'h53D3DF2050DF;
  localparam logic [27:0]  MC   = 28'h123456D;
  localparam logic [27:0]  GC   = 28'h0137F01;
  localparam logic [48:0]  PCT  = {7'h0A, 7'h11, 7'h19, 7'h1E, 7'h21, 7'h24, 7'h5F};
  localparam logic [41:0]  DB   = {6'h22, 6'h20, 6'h1B, 6'h14, 6'h08, 6'h22, 6'h20};
  localparam logic [55:0]  RD   = 56'h0803690100;
  localparam logic [55:0]  PSW  = 56'h03030303010102;
  logic i_core_clk = 1'b0;
  logic i_reset_n  = 1'b0;
  logic i_clk_en   = 1'b1;
  logic cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] cmd_byte, rsp_byte;
  logic [3:0] mod_index, rx_gain, load_mod;
  logic [6:0] mod_pct;
  logic [5:0] gain_db;
  logic [1:0] demod_sens;
  logic saving, mode_ok;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  always #20 i_core_clk = ~i_core_clk;
  acr_host_model host_u (.i_clk(i_core_clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
    .i_rsp_byte(rsp_byte), .i_rsp_last(rsp_last), .o_cmd_valid(cmd_valid),
    .o_cmd_byte(cmd_byte), .o_cmd_last(cmd_last), .o_rsp_ready(rsp_ready));
  acr_regs dut_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte), .i_cmd_last(cmd_last),
    .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte),
    .o_rsp_last(rsp_last), .i_rsp_ready(rsp_ready), .o_mod_index(mod_index),
    .o_rx_gain(rx_gain), .o_mod_percent(mod_pct), .o_rx_gain_db(gain_db),
    .o_load_mod_index(load_mod), .o_demod_sens(demod_sens),
    .o_driver_supply_saving(saving), .o_reader_mode_possible(mode_ok));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xact(input logic [55:0] f, input int n, input logic [23:0] exp, input int en);
    logic [23:0] r;
    int k;
    host_u.send_frame(f, n);
    host_u.get_resp(r, k);
    check(r, exp);
    check(k, en);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a hang in a handshake wait ends here; normal run is under 2000 cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_core_clk);
    #1;
    i_reset_n = 1'b1;
    @(posedge i_core_clk);
    #1;
    xact(56'h0903680001, 5, 24'h0000, 2);
    xact(RD, 5, 24'h000100, 3);
    for (int i = 0; i < 6; i++) begin
      xact(PSEL[32*(5-i) +: 32], 4, 24'h0000, 2);
      xact(RD, 5, {16'h0001, PDEF[8*(5-i) +: 8]}, 3);
      check({mod_index, rx_gain}, PDEF[8*(5-i) +: 8]);
    end
    xact(56'h0903680004, 5, 24'h0000, 2);
    xact(RD, 5, 24'h000127, 3);
    check({demod_sens, load_mod}, 6'h27);
    xact(56'h090468000415, 6, 24'h0000, 2);
    xact(RD, 5, 24'h000115, 3);
    check({demod_sens, load_mod}, 6'h15);
    xact(56'h09046801041F, 6, 24'h0000, 2);
    xact(RD, 5, 24'h000100, 3);
    check(load_mod, 4'hF);
    xact(56'h0903680001, 5, 24'h0000, 2);
    xact(RD, 5, 24'h0001DF, 3);
    for (int i = 0; i < 7; i++) begin
      xact({16'h0202, PSW[8*(6-i) +: 8], 8'h00}, 4, 24'h0000, 2);
      xact({40'h0904680001, MC[4*(6-i) +: 4], GC[4*(6-i) +: 4]}, 6, 24'h0000, 2);
      check(mod_pct, PCT[7*(6-i) +: 7]);
      check(gain_db, DB[6*(6-i) +: 6]);
    end
    host_u.set_slow(1'b1);
    xact(RD, 5, 24'h0001D1, 3);
    @(posedge i_core_clk);
    #1;
    host_u.set_slow(1'b0);
    xact(56'h02020200, 4, 24'h0000, 2);
    xact(RD, 5, 24'h0001DF, 3);
    xact(56'h02020700, 4, 24'h0000, 2);
    xact(RD, 5, 24'h0001DF, 3);
    xact(56'h08026901, 4, 24'h8200, 2);
    xact(56'h09026800, 4, 24'h8200, 2);
    xact(56'h09046A000001, 6, 24'h0000, 2);
    check({saving, mode_ok}, 2'h2);
    xact(56'h09046A000000, 6, 24'h0000, 2);
    check({saving, mode_ok}, 2'h1);
    i_reset_n = 1'b0;
    @(posedge i_core_clk);
    #1;
    check({mod_index, rx_gain, mode_ok}, 9'h001);
    i_reset_n = 1'b1;
    @(posedge i_core_clk);
    #1;
    xact(56'h0903680001, 5, 24'h0000, 2);
    xact(RD, 5, 24'h000100, 3);
    print_verdict();
  end
endmodule // acr_regs_tb_top
`default_nettype wire
